// ---- src/otp_config_ctrl.sv ----
// configuration store, node identity, current selection and chopper of the drive
`timescale 1ns/10ps
module otp_config_ctrl #(
  parameter logic [7:0] FACTORY_TRIM_0 = 8'h00,
  parameter logic [7:0] FACTORY_TRIM_1 = 8'h00,
  parameter int CHOP_CYCLES = int'(otp_cfg_pkg::CLK_FREQ_HZ / otp_cfg_pkg::CHOP_FREQ_HZ),
  parameter int COILS = otp_cfg_pkg::COILS
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // command port
  input wire logic cmd_valid,
  input wire otp_cfg_pkg::cmd_t cmd,
  output logic cmd_ready_reg,
  output logic rsp_valid_reg,
  output logic [7:0] rsp_data_reg,
  output logic pos_go_reg,
  // strap pins and supply monitor
  input wire logic strap_pin_0,
  input wire logic strap_pin_1,
  input wire logic strap_pin_2,
  input wire logic supply_dropout,
  output logic supply_loss_flag_reg,
  // motion events
  input wire logic motion_start,
  input wire logic motion_end,
  input wire logic half_step_tick,
  // coil current loop
  input wire logic [COILS-1:0][otp_cfg_pkg::MA_W-1:0] coil_meas_ma,
  output otp_cfg_pkg::bridge_t [COILS-1:0] bridge_reg,
  // working configuration
  output logic [otp_cfg_pkg::OTP_BYTES-1:0][7:0] params_reg,
  output logic [otp_cfg_pkg::NODE_W-1:0] node_id_reg,
  output otp_cfg_pkg::step_mode_t step_mode_reg,
  output logic [otp_cfg_pkg::CUR_W-1:0] cur_code_reg
);
  typedef enum logic [1:0] {ST_COPY_REQ, ST_COPY_TAKE, ST_IDLE, ST_READ_WAIT} ctrl_state_t;
  typedef enum logic [1:0] {HS_RUN, HS_SETTLE, HS_HOLD} hold_state_t;

  localparam int CHOP_W = $clog2(CHOP_CYCLES);

  if (CHOP_CYCLES < 2) begin : g_bad_chop
    $error("otp_config_ctrl: chopper period must span at least two cycles");
  end
  if (COILS < 1) begin : g_bad_coils
    $error("otp_config_ctrl: at least one coil is needed");
  end

  ctrl_state_t state_reg, state_next;
  logic [otp_cfg_pkg::OTP_AW-1:0] copy_idx_reg, copy_idx_next;
  logic [otp_cfg_pkg::OTP_AW-1:0] rd_addr;
  logic [7:0] rd_data;
  logic factory_seal, user_seal;
  logic burn_en;
  logic loaded_reg, loaded_next;
  logic cmd_ready_next, rsp_valid_next, pos_go_next, loss_next;
  logic [7:0] rsp_data_next;
  logic [otp_cfg_pkg::OTP_BYTES-1:0][7:0] params_next;
  logic take, addressed, pos_allowed, status_take;
  logic [otp_cfg_pkg::NODE_W-1:0] node_id_next;
  logic [otp_cfg_pkg::PA_W-1:0] pa;
  logic id_exp;
  hold_state_t hold_state_reg, hold_state_next;
  logic [1:0] hold_cnt_reg, hold_cnt_next;
  logic [otp_cfg_pkg::CUR_W-1:0] cur_code_next, irun, ihold;
  otp_cfg_pkg::step_mode_t step_mode_next;
  logic [CHOP_W-1:0] chop_cnt_reg, chop_cnt_next;
  logic chop_tick_reg, chop_tick_next;
  logic [otp_cfg_pkg::MA_W-1:0] target_ma;

  otp_array #(
    .BYTES(otp_cfg_pkg::OTP_BYTES),
    .FACTORY_TRIM_0(FACTORY_TRIM_0),
    .FACTORY_TRIM_1(FACTORY_TRIM_1)
  ) u_otp (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .burn_en(burn_en),
    .burn_addr(cmd.addr),
    .burn_bits(cmd.data),
    .rd_addr(rd_addr),
    .rd_data_reg(rd_data),
    .factory_seal(factory_seal),
    .user_seal(user_seal)
  );

  assign pa = params_reg[otp_cfg_pkg::ADDR_NODE_ID][otp_cfg_pkg::PA_W-1:0];
  assign id_exp = params_reg[otp_cfg_pkg::ADDR_NODE_ID][otp_cfg_pkg::ID_EXP_BIT];
  assign irun = params_reg[otp_cfg_pkg::ADDR_CURRENTS][otp_cfg_pkg::IRUN_LSB +: otp_cfg_pkg::CUR_W];
  assign ihold = params_reg[otp_cfg_pkg::ADDR_CURRENTS][otp_cfg_pkg::IHOLD_LSB +: otp_cfg_pkg::CUR_W];

  // command decode and working memory
  always_comb begin
    addressed = !cmd.node_select || (cmd.node_addr == node_id_reg);
    take = cmd_valid && cmd_ready_reg && addressed;
    status_take = take && (cmd.op == otp_cfg_pkg::OP_FULL_STATUS);
    // the seal bit stands for a finished nonvolatile programming run
    pos_allowed = !supply_loss_flag_reg && (user_seal || loaded_reg);
    state_next = state_reg;
    copy_idx_next = copy_idx_reg;
    params_next = params_reg;
    loaded_next = loaded_reg;
    rd_addr = copy_idx_reg;
    burn_en = 1'b0;
    rsp_valid_next = 1'b0;
    rsp_data_next = rsp_data_reg;
    pos_go_next = 1'b0;
    unique case (state_reg)
      ST_COPY_REQ: begin
        state_next = ST_COPY_TAKE;
      end
      ST_COPY_TAKE: begin
        params_next[copy_idx_reg] = rd_data;
        copy_idx_next = copy_idx_reg + 3'h1;
        state_next = (copy_idx_reg == otp_cfg_pkg::ADDR_MODE_SEALS) ? ST_IDLE : ST_COPY_REQ;
      end
      ST_IDLE: begin
        rd_addr = cmd.addr;
        if (take) begin
          unique case (cmd.op)
            otp_cfg_pkg::OP_LOAD_PARAMS: begin
              // only working memory changes; burned cells stay as they are
              params_next[cmd.addr] = cmd.data;
              loaded_next = 1'b1;
            end
            otp_cfg_pkg::OP_BURN_BYTE: begin
              burn_en = 1'b1;
            end
            otp_cfg_pkg::OP_READ_BACK_NV: begin
              state_next = ST_READ_WAIT;
            end
            otp_cfg_pkg::OP_FULL_STATUS: begin
              rsp_valid_next = 1'b1;
              rsp_data_next = 8'h00;
              rsp_data_next[otp_cfg_pkg::STAT_LOSS_BIT] = supply_loss_flag_reg;
              rsp_data_next[otp_cfg_pkg::STAT_HOLD_BIT] = (hold_state_reg == HS_HOLD);
              rsp_data_next[otp_cfg_pkg::STAT_LOADED_BIT] = loaded_reg;
            end
            otp_cfg_pkg::OP_POSITION: begin
              pos_go_next = pos_allowed;
            end
            default: begin
            end
          endcase
        end
      end
      ST_READ_WAIT: begin
        rsp_valid_next = 1'b1;
        rsp_data_next = rd_data;
        state_next = ST_IDLE;
      end
    endcase
    cmd_ready_next = (state_next == ST_IDLE);
    // a dropout in the clearing cycle still leaves the flag set
    loss_next = supply_dropout || (supply_loss_flag_reg && !status_take);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_COPY_REQ;
      copy_idx_reg <= otp_cfg_pkg::ADDR_CLOCK_TRIM;
      params_reg <= '0;
      loaded_reg <= 1'b0;
      cmd_ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
      pos_go_reg <= 1'b0;
      supply_loss_flag_reg <= 1'b1;
    end else if (clk_en) begin
      state_reg <= state_next;
      copy_idx_reg <= copy_idx_next;
      params_reg <= params_next;
      loaded_reg <= loaded_next;
      cmd_ready_reg <= cmd_ready_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
      pos_go_reg <= pos_go_next;
      supply_loss_flag_reg <= loss_next;
    end
  end

  // identity, resolution and run/hold current
  always_comb begin
    if (id_exp) begin
      node_id_next = {pa[0], strap_pin_0, strap_pin_1, strap_pin_2, pa[3:1]};
    end else begin
      node_id_next = {strap_pin_0, strap_pin_1, strap_pin_2, pa};
    end
    step_mode_next = otp_cfg_pkg::step_mode_t'(
      params_reg[otp_cfg_pkg::ADDR_MODE_SEALS][otp_cfg_pkg::STEP_LSB +: otp_cfg_pkg::STEP_W]);
    hold_state_next = hold_state_reg;
    hold_cnt_next = hold_cnt_reg;
    unique case (hold_state_reg)
      HS_RUN, HS_HOLD: begin
        if (motion_end) begin
          hold_state_next = HS_SETTLE;
          hold_cnt_next = 2'h0;
        end
      end
      HS_SETTLE: begin
        // ticks come at minimum speed; run current stays frozen meanwhile
        if (half_step_tick) begin
          hold_cnt_next = hold_cnt_reg + 2'h1;
          if (hold_cnt_reg == otp_cfg_pkg::HOLD_LAST) begin
            hold_state_next = HS_HOLD;
          end
        end
      end
    endcase
    if (motion_start) begin
      hold_state_next = HS_RUN;
    end
    cur_code_next = (hold_state_reg == HS_HOLD) ? ihold : irun;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      node_id_reg <= '0;
      step_mode_reg <= otp_cfg_pkg::SM_HALF;
      hold_state_reg <= HS_HOLD;
      hold_cnt_reg <= 2'h0;
      cur_code_reg <= '0;
    end else if (clk_en) begin
      node_id_reg <= node_id_next;
      step_mode_reg <= step_mode_next;
      hold_state_reg <= hold_state_next;
      hold_cnt_reg <= hold_cnt_next;
      cur_code_reg <= cur_code_next;
    end
  end

  // fixed-frequency chopper
  assign target_ma = otp_cfg_pkg::PEAK_MA[cur_code_reg];

  always_comb begin
    chop_tick_next = (chop_cnt_reg == CHOP_W'(CHOP_CYCLES - 1));
    chop_cnt_next = chop_tick_next ? '0 : chop_cnt_reg + CHOP_W'(1);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chop_cnt_reg <= '0;
      chop_tick_reg <= 1'b0;
    end else if (clk_en) begin
      chop_cnt_reg <= chop_cnt_next;
      chop_tick_reg <= chop_tick_next;
    end
  end

  for (genvar c = 0; c < COILS; c++) begin : g_coil
    otp_cfg_pkg::bridge_t br_next;
    logic [otp_cfg_pkg::MA_W:0] excess;
    always_comb begin
      excess = {1'b0, coil_meas_ma[c]} - {1'b0, target_ma};
      br_next = bridge_reg[c];
      if (chop_tick_reg) begin
        if (coil_meas_ma[c] < target_ma) begin
          br_next = otp_cfg_pkg::BR_RAISE;
        end else if (excess > {1'b0, otp_cfg_pkg::FAST_MARGIN_MA}) begin
          // fast decay only for a large overshoot; it ripples more
          br_next = otp_cfg_pkg::BR_FAST_DECAY;
        end else begin
          br_next = otp_cfg_pkg::BR_SLOW_DECAY;
        end
      end
    end
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        bridge_reg[c] <= otp_cfg_pkg::BR_SLOW_DECAY;
      end else if (clk_en) begin
        bridge_reg[c] <= br_next;
      end
    end
    a_chop_raise: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && chop_tick_reg && coil_meas_ma[c] < target_ma |=> bridge_reg[c] == otp_cfg_pkg::BR_RAISE)
      else $error("coil below target was not driven up");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_read_taken;
    clk_en && take && cmd.op == otp_cfg_pkg::OP_READ_BACK_NV ##1 clk_en;
  endsequence
  sequence s_hold_entry;
    clk_en && hold_state_reg == HS_SETTLE && half_step_tick && !motion_start &&
    hold_cnt_reg == otp_cfg_pkg::HOLD_LAST;
  endsequence

  a_pos_gate: assert property ($rose(pos_go_reg) |->
    !$past(supply_loss_flag_reg) && ($past(loaded_reg) || $past(user_seal)))
    else $error("positioning accepted while blocked");
  a_loss_set: assert property (clk_en && supply_dropout |=> supply_loss_flag_reg)
    else $error("dropout did not set the supply-loss flag");
  a_loss_clear: assert property (clk_en && status_take && !supply_dropout |=> !supply_loss_flag_reg)
    else $error("full-status read did not clear the supply-loss flag");
  a_read_latency: assert property (s_read_taken |=> rsp_valid_reg && rsp_data_reg == $past(rd_data))
    else $error("read-back answer missing two cycles after the request");
  a_hold_entry: assert property (s_hold_entry |=> hold_state_reg == HS_HOLD ##1
    (!$past(clk_en) || cur_code_reg == $past(ihold)))
    else $error("hold current not applied after two half steps");
  // the first edge after reset release still shows reset values, so it is left out
  a_node_map: assert property ($past(resetn) && $past(clk_en) && !$past(id_exp) |-> node_id_reg ==
    {$past(strap_pin_0), $past(strap_pin_1), $past(strap_pin_2), $past(pa)})
    else $error("node identity does not follow straps and stored bits");
  a_step_mode: assert property ($past(resetn) && $past(clk_en) |->
    step_mode_reg == otp_cfg_pkg::step_mode_t'(
    $past(params_reg[otp_cfg_pkg::ADDR_MODE_SEALS][otp_cfg_pkg::STEP_LSB +: otp_cfg_pkg::STEP_W])))
    else $error("step resolution does not follow the stored field");
endmodule

// ---- pkg/otp_cfg_pkg.sv ----
// constants, field layout and carrier types of the configuration store
// Overview of operation
// - eight one-time-programmable configuration bytes live at addresses 0x00 to 0x07
// - positioning commands ignored when unprogrammed and unloaded, or supply-loss flag set
// - unburned bits read zero; burning turns a bit permanently to one
// - a burn never touches a bit that already holds one
// - one burn command programs exactly one byte; one command per byte
// - factory seal locks bytes 0x00-0x01, user seal locks bytes 0x02-0x07
// - calibration bytes and factory seal are already burned at delivery
// - two-bit resolution selects half, quarter, eighth or sixteenth stepping
// - four-bit run and hold codes map to peak currents 59 mA to 800 mA
// - after motion keep run current for two slow half steps, then hold current
// - each chopper period raise current below target, lower it above target
// - lowering uses slow decay or, for larger excess, fast decay
// - the node answers to a seven-bit identity, up to 128 nodes
// - identity combines four nonvolatile bits with three strap pin levels
// - expansion bit selects how straps and nonvolatile bits form the identity
// - a command with all-nodes select at zero is accepted by every node
// - supply-loss flag set at power-up or dropout, cleared by full-status read
package otp_cfg_pkg;
  localparam int OTP_BYTES = 8;
  localparam int OTP_AW = 3;
  localparam int CUR_W = 4;
  localparam int STEP_W = 2;
  localparam int NODE_W = 7;
  localparam int PA_W = 4;
  localparam int MA_W = 10;
  localparam int COILS = 2;

  localparam logic [OTP_AW-1:0] ADDR_CLOCK_TRIM = 3'h0;
  localparam logic [OTP_AW-1:0] ADDR_BUS_TRIM = 3'h1;
  localparam logic [OTP_AW-1:0] ADDR_NODE_ID = 3'h2;
  localparam logic [OTP_AW-1:0] ADDR_CURRENTS = 3'h3;
  localparam logic [OTP_AW-1:0] ADDR_SPEEDS = 3'h4;
  localparam logic [OTP_AW-1:0] ADDR_FALLBACK_HI = 3'h5;
  localparam logic [OTP_AW-1:0] ADDR_FALLBACK_LO = 3'h6;
  localparam logic [OTP_AW-1:0] ADDR_MODE_SEALS = 3'h7;
  localparam logic [OTP_AW-1:0] FACTORY_LAST = ADDR_BUS_TRIM;

  localparam int ID_EXP_BIT = 7;
  localparam int IRUN_LSB = 4;
  localparam int IHOLD_LSB = 0;
  localparam int STEP_LSB = 2;
  localparam int FSEAL_BIT = 1;
  localparam int USEAL_BIT = 0;
  localparam logic [7:0] FSEAL_MASK = 8'h02;

  localparam int STAT_LOSS_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;
  localparam int STAT_LOADED_BIT = 2;

  localparam logic [1:0] HOLD_HALF_STEPS = 2'h2;
  localparam logic [1:0] HOLD_LAST = HOLD_HALF_STEPS - 2'h1;

  localparam longint CLK_FREQ_HZ = 125_000_000;
  localparam longint CHOP_FREQ_HZ = 20_000;
  localparam logic [MA_W-1:0] FAST_MARGIN_MA = 10'h020;

  localparam logic [MA_W-1:0] PEAK_MA [16] = '{
    10'h03B, 10'h047, 10'h054, 10'h064, 10'h077, 10'h08D, 10'h0A8, 10'h0C8,
    10'h0EE, 10'h11B, 10'h150, 10'h190, 10'h1DC, 10'h236, 10'h2A1, 10'h320
  };

  typedef enum logic [2:0] {
    OP_LOAD_PARAMS,
    OP_BURN_BYTE,
    OP_READ_BACK_NV,
    OP_FULL_STATUS,
    OP_POSITION
  } cmd_op_t;

  typedef enum logic [1:0] {
    SM_HALF,
    SM_QUARTER,
    SM_EIGHTH,
    SM_SIXTEENTH
  } step_mode_t;

  typedef enum logic [1:0] {
    BR_RAISE,
    BR_SLOW_DECAY,
    BR_FAST_DECAY
  } bridge_t;

  typedef struct packed {
    cmd_op_t op;
    logic node_select;
    logic [NODE_W-1:0] node_addr;
    logic [OTP_AW-1:0] addr;
    logic [7:0] data;
  } cmd_t;
endpackage

// ---- src/otp_array.sv ----
// one-time-programmable byte array with burn port and registered read
`timescale 1ns/10ps
module otp_array #(
  parameter int BYTES = otp_cfg_pkg::OTP_BYTES,
  parameter logic [7:0] FACTORY_TRIM_0 = 8'h00,
  parameter logic [7:0] FACTORY_TRIM_1 = 8'h00
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // burn port
  input wire logic burn_en,
  input wire logic [otp_cfg_pkg::OTP_AW-1:0] burn_addr,
  input wire logic [7:0] burn_bits,
  // read port
  input wire logic [otp_cfg_pkg::OTP_AW-1:0] rd_addr,
  output logic [7:0] rd_data_reg,
  // seal state
  output logic factory_seal,
  output logic user_seal
);
  logic [7:0] cell_reg [BYTES];
  logic [7:0] cell_next [BYTES];
  logic [7:0] rd_data_next;
  logic [7:0] burn_old;
  logic burn_sealed;

  if (BYTES != otp_cfg_pkg::OTP_BYTES) begin : g_bad_size
    $error("otp_array: the field layout needs exactly eight bytes");
  end

  assign factory_seal = cell_reg[otp_cfg_pkg::ADDR_MODE_SEALS][otp_cfg_pkg::FSEAL_BIT];
  assign user_seal = cell_reg[otp_cfg_pkg::ADDR_MODE_SEALS][otp_cfg_pkg::USEAL_BIT];
  assign burn_old = cell_reg[burn_addr];

  always_comb begin
    burn_sealed = (burn_addr <= otp_cfg_pkg::FACTORY_LAST) ? factory_seal : user_seal;
    cell_next = cell_reg;
    if (burn_en && !burn_sealed) begin
      // or-ing means a bit already at one is never pulsed again
      cell_next[burn_addr] = burn_old | burn_bits;
    end
    rd_data_next = cell_reg[rd_addr];
  end

  for (genvar i = 0; i < BYTES; i++) begin : g_cell
    localparam logic [7:0] INIT = (i == int'(otp_cfg_pkg::ADDR_CLOCK_TRIM)) ? FACTORY_TRIM_0 :
                                  (i == int'(otp_cfg_pkg::ADDR_BUS_TRIM)) ? FACTORY_TRIM_1 :
                                  (i == int'(otp_cfg_pkg::ADDR_MODE_SEALS)) ? otp_cfg_pkg::FSEAL_MASK : 8'h00;
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        cell_reg[i] <= INIT;
      end else if (clk_en) begin
        cell_reg[i] <= cell_next[i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_reg <= 8'h00;
    end else if (clk_en) begin
      rd_data_reg <= rd_data_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_seal_blocks_burn: assert property (
    clk_en && burn_en && burn_sealed |=> cell_reg[$past(burn_addr)] == $past(burn_old))
    else $error("burn changed a sealed byte");

  a_burn_only_sets: assert property (
    clk_en && burn_en && !burn_sealed |=> cell_reg[$past(burn_addr)] == ($past(burn_old) | $past(burn_bits)))
    else $error("burn result is not old value or-ed with burn bits");
endmodule

// ---- tb/cmd_master.sv ----
// serial bus master model that issues configuration commands
`timescale 1ns/10ps
module cmd_master (
  // clock
  input wire logic clk,
  // command port
  output logic cmd_valid,
  output otp_cfg_pkg::cmd_t cmd,
  input wire logic cmd_ready_reg,
  input wire logic rsp_valid_reg,
  input wire logic [7:0] rsp_data_reg
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // one command carries one byte; a caller burns byte by byte
  task automatic send(input logic [2:0] op, input logic nsel, input logic [6:0] naddr,
                      input logic [2:0] addr, input logic [7:0] data, output logic ok);
    ok = 1'b0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{otp_cfg_pkg::cmd_op_t'(op), nsel, naddr, addr, data};
    for (int i = 0; i < 64 && !ok; i++) begin
      @(posedge clk);
      ok = (cmd_ready_reg === 1'b1);
    end
    cmd_valid <= 1'b0;
    // a released command must not keep showing the old fields
    cmd <= otp_cfg_pkg::cmd_t'(~cmd);
  endtask
  // answered commands; a short bound since the answer follows in one or two edges
  task automatic query(input logic [2:0] op, input logic nsel, input logic [6:0] naddr,
                       input logic [2:0] addr, output logic [7:0] data, output logic ok);
    logic taken;
    send(op, nsel, naddr, addr, 8'h00, taken);
    ok = 1'b0;
    data = 8'h00;
    for (int i = 0; i < 4 && taken && !ok; i++) begin
      @(posedge clk);
      ok = (rsp_valid_reg === 1'b1);
      data = rsp_data_reg;
    end
  endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench of the configuration store
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] TRIM0 = 8'hA5; // arbitrary trim value
  localparam logic [7:0] TRIM1 = 8'h3C; // arbitrary trim value
  localparam int CHOP = 8;
  localparam logic [2:0] OP_LD = otp_cfg_pkg::OP_LOAD_PARAMS;
  localparam logic [2:0] OP_BN = otp_cfg_pkg::OP_BURN_BYTE;
  localparam logic [2:0] OP_RB = otp_cfg_pkg::OP_READ_BACK_NV;
  localparam logic [2:0] OP_ST = otp_cfg_pkg::OP_FULL_STATUS;
  localparam logic [2:0] OP_POS = otp_cfg_pkg::OP_POSITION;
  logic clk, resetn, clk_en, cmd_valid, strap_pin_0, strap_pin_1, strap_pin_2, supply_dropout;
  logic motion_start, motion_end, half_step_tick, cmd_ready_reg, rsp_valid_reg, pos_go_reg;
  logic supply_loss_flag_reg, ok;
  logic [7:0] rsp_data_reg, rd;
  otp_cfg_pkg::cmd_t cmd;
  logic [1:0][otp_cfg_pkg::MA_W-1:0] coil_meas_ma;
  otp_cfg_pkg::bridge_t [1:0] bridge_reg;
  logic [7:0][7:0] params_reg;
  logic [6:0] node_id_reg;
  otp_cfg_pkg::step_mode_t step_mode_reg;
  logic [3:0] cur_code_reg;
  int n_fail = 0;
  int n_tests = 0;
  int n_go = 0;

  otp_config_ctrl #(.FACTORY_TRIM_0(TRIM0), .FACTORY_TRIM_1(TRIM1), .CHOP_CYCLES(CHOP), .COILS(2)) DUT (
    .clk(clk), .resetn(resetn), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready_reg(cmd_ready_reg), .rsp_valid_reg(rsp_valid_reg), .rsp_data_reg(rsp_data_reg),
    .pos_go_reg(pos_go_reg), .strap_pin_0(strap_pin_0), .strap_pin_1(strap_pin_1),
    .strap_pin_2(strap_pin_2), .supply_dropout(supply_dropout),
    .supply_loss_flag_reg(supply_loss_flag_reg), .motion_start(motion_start), .motion_end(motion_end),
    .half_step_tick(half_step_tick), .coil_meas_ma(coil_meas_ma), .bridge_reg(bridge_reg),
    .params_reg(params_reg), .node_id_reg(node_id_reg), .step_mode_reg(step_mode_reg),
    .cur_code_reg(cur_code_reg)
  );
  cmd_master m (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready_reg(cmd_ready_reg),
    .rsp_valid_reg(rsp_valid_reg), .rsp_data_reg(rsp_data_reg));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (pos_go_reg === 1'b1) n_go <= n_go + 1;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rb(input logic [2:0] a, input logic [7:0] exp);
    m.query(OP_RB, 1'b0, 7'h00, a, rd, ok);
    check({ok, rd}, {1'b1, exp});
  endtask
  task automatic wr(input logic [2:0] op, input logic [2:0] a, input logic [7:0] d);
    m.send(op, 1'b0, 7'h00, a, d, ok);
    check(ok, 1'b1);
    repeat (3) @(posedge clk);
  endtask
  task automatic stat(input logic loss);
    m.query(OP_ST, 1'b0, 7'h00, 3'h0, rd, ok);
    check({ok, rd[0]}, {1'b1, loss});
  endtask
  task automatic pos(input int exp);
    int g;
    g = n_go;
    wr(OP_POS, 3'h0, 8'h00);
    check(n_go - g, exp[15:0]);
  endtask
  // drives motion_start, motion_end, half_step_tick as one-cycle pulses
  task automatic pulse(input logic [2:0] v);
    @(posedge clk);
    {motion_start, motion_end, half_step_tick} <= v;
    @(posedge clk);
    {motion_start, motion_end, half_step_tick} <= 3'h0;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    {strap_pin_0, strap_pin_1, strap_pin_2} = 3'b101;
    {supply_dropout, motion_start, motion_end, half_step_tick} = 4'h0;
    coil_meas_ma = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 100 && cmd_ready_reg !== 1'b1; i++) @(posedge clk);
    check(cmd_ready_reg, 1'b1);
    check(supply_loss_flag_reg, 1'b1);
    check(params_reg[0], TRIM0);
    for (int i = 0; i < 8; i++) rb(i[2:0], i == 0 ? TRIM0 : i == 1 ? TRIM1 : i == 7 ? 8'h02 : 8'h00);
    stat(1'b1);
    stat(1'b0);
    pos(0);
    wr(OP_BN, 3'h0, 8'h5A);
    rb(3'h0, TRIM0);
    wr(OP_BN, 3'h3, 8'h5A);
    rb(3'h3, 8'h5A);
    wr(OP_BN, 3'h3, 8'h0F);
    rb(3'h3, 8'h5F);
    rb(3'h4, 8'h00);
    check(cur_code_reg, 4'h0);
    wr(OP_LD, 3'h3, 8'hC3);
    check(params_reg[3], 8'hC3);
    rb(3'h3, 8'h5F);
    check(cur_code_reg, 4'h3);
    pos(1);
    @(posedge clk);
    supply_dropout <= 1'b1;
    @(posedge clk);
    supply_dropout <= 1'b0;
    pos(0);
    stat(1'b1);
    pos(1);
    wr(OP_LD, 3'h2, 8'h0B);
    check(node_id_reg, 7'h5B);
    wr(OP_LD, 3'h2, 8'h8B);
    check(node_id_reg, 7'h6D);
    m.query(OP_ST, 1'b1, 7'h6C, 3'h0, rd, ok);
    check(ok, 1'b0);
    m.query(OP_ST, 1'b1, 7'h6D, 3'h0, rd, ok);
    check(ok, 1'b1);
    m.query(OP_ST, 1'b0, 7'h00, 3'h0, rd, ok);
    check(ok, 1'b1);
    // a dropout while the clock enable is low must leave the frozen flag alone
    @(posedge clk);
    clk_en <= 1'b0;
    supply_dropout <= 1'b1;
    @(posedge clk);
    supply_dropout <= 1'b0;
    @(posedge clk);
    clk_en <= 1'b1;
    check(supply_loss_flag_reg, 1'b0);
    for (int s = 0; s < 4; s++) begin
      wr(OP_LD, 3'h7, {4'h0, s[1:0], 2'h0});
      check(step_mode_reg, s[1:0]);
    end
    pulse(3'b100);
    check(cur_code_reg, 4'hC);
    pulse(3'b010);
    pulse(3'b001);
    check(cur_code_reg, 4'hC);
    pulse(3'b001);
    check(cur_code_reg, 4'h3);
    // hold code 3 targets 100 mA: below, slightly above, far above
    coil_meas_ma <= {10'h032, 10'h032};
    repeat (3 * CHOP + 4) @(posedge clk);
    check(bridge_reg, {otp_cfg_pkg::BR_RAISE, otp_cfg_pkg::BR_RAISE});
    coil_meas_ma <= {10'h0C8, 10'h06E};
    repeat (3 * CHOP + 4) @(posedge clk);
    check(bridge_reg, {otp_cfg_pkg::BR_FAST_DECAY, otp_cfg_pkg::BR_SLOW_DECAY});
    final_report();
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    $display("[ERR] %0t run limit reached", $time);
    final_report();
  end
endmodule
